// >>> pkg/sc_dram_map.vh
// timing constants and field layout for the static-column dram controller
// assumes a single clock; cycle counts derive from SYS_CLK_NS
`ifndef SC_DRAM_MAP_VH
`define SC_DRAM_MAP_VH

`define SYS_CLK_NS        100
`define ADDR_W            10
`define DATA_W            4
// least times round up, in ns unless named otherwise
`define CYC_MIN(ns)       ((((ns) + `SYS_CLK_NS - 1) / `SYS_CLK_NS) < 1 ? 1 : \
                           (((ns) + `SYS_CLK_NS - 1) / `SYS_CLK_NS))
`define POWERUP_US        200
`define POWERUP_CYC       ((`POWERUP_US * 1000 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define IDLE_LIMIT_MS     16
`define IDLE_LIMIT_CYC    ((`IDLE_LIMIT_MS * 1000000) / `SYS_CLK_NS)
`define WAKE_CYCLES       8
`define REFRESH_MS        16
`define REFRESH_ROWS      1024
`define REFRESH_INT_CYC   ((`REFRESH_MS * 1000000) / `SYS_CLK_NS / `REFRESH_ROWS)
`define RAS_WIDTH_NS      100
`define RAS_PRECHARGE_NS  70
`define ROW_TO_SELECT_NS  25
`define ROW_HOLD_NS       15
`define SEL_WIDTH_NS      25
`define COL_HOLD_NS       10
`define DATA_HOLD_NS      20
`define WRITE_LEAD_NS     25
`define SEL_SETUP_NS      5
`define SEL_HOLD_REF_NS   20
`define WRITE_REF_NS      10
`define READ_ACCESS_NS    100

`endif

// >>> design/wait_timer.v
// down-counter that loads a cycle count and flags expiry
// assumes load takes priority over counting
module wait_timer #(
  parameter W = 24
) (
  input  wire         ref_clk,  // system clock
  input  wire         rst,      // async reset, high
  input  wire         load,     // load new count
  input  wire [W-1:0] count,    // cycles to wait
  output reg          done_r    // count reached zero
);
  reg [W-1:0] cnt_r;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= {W{1'b0}};
      done_r <= 1'b1;
    end else if (load) begin
      cnt_r  <= count;
      done_r <= (count == {W{1'b0}});
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// >>> design/refresh_scheduler.v
// raises a refresh request at a fixed interval, held until granted
// assumes grant is a one-cycle pulse from the sequencer
module refresh_scheduler #(
  parameter INTERVAL = 156
) (
  input  wire ref_clk,  // system clock
  input  wire rst,      // async reset, high
  input  wire enable,   // start scheduling after init
  input  wire grant,    // refresh taken
  output reg  req_r     // refresh owed
);
  reg [15:0] tick_r;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 16'h0000;
      req_r  <= 1'b0;
    end else if (enable) begin
      if (tick_r == INTERVAL[15:0] - 16'h0001) begin
        tick_r <= 16'h0000;
        req_r  <= 1'b1;  // a tick in the grant cycle wins
      end else begin
        tick_r <= tick_r + 16'h0001;
        if (grant)
          req_r <= 1'b0;
      end
    end
  end
endmodule

// >>> design/sc_dram_ctrl.v
// controller driving a 1M x 4 static-column dram through its pins
// assumes pins sampled synchronous to ref_clk; device pins resolved in bench
`include "sc_dram_map.vh"
module sc_dram_ctrl #(
  parameter POWERUP_CYC  = `POWERUP_CYC,
  parameter IDLE_CYC     = `IDLE_LIMIT_CYC,
  parameter REFRESH_CYC  = `REFRESH_INT_CYC
) (
  input  wire                ref_clk,     // 10 MHz system clock
  input  wire                rst,         // async reset, high
  input  wire                reqValid,    // user request pending
  input  wire                reqWrite,    // 1 write, 0 read
  input  wire                reqTest,     // request test-mode entry cycle
  input  wire [19:0]         reqAddr,     // row in [19:10], column in [9:0]
  input  wire [3:0]          reqData,     // write data
  output reg                 reqReady_r,  // request accepted pulse
  output reg                 rspValid_r,  // read data valid pulse
  output reg  [3:0]          rspData_r,   // read data
  output reg                 initDone_r,  // wake sequence complete
  output reg  [9:0]          muxAddr_r,   // mux_address_pins
  output reg                 rowStrobeN_r,// row strobe, active low
  output reg                 selStrobeN_r,// select strobe, active low
  output reg                 writeN_r,    // write strobe, active low
  output reg                 outEnN_r,    // output enable, active low
  input  wire [3:0]          dataIn,      // data_pins input
  output reg  [3:0]          dataOut_r,   // data_pins output
  output reg                 dataOeN_r    // data_pins enable, low drives
);
  localparam ST_POWER = 4'h0;
  localparam ST_WAKEA = 4'h1;
  localparam ST_WAKEP = 4'h2;
  localparam ST_IDLE  = 4'h3;
  localparam ST_ROW   = 4'h4;
  localparam ST_SEL   = 4'h5;
  localparam ST_HOLD  = 4'h6;
  localparam ST_CLOSE = 4'h7;
  localparam ST_PRE   = 4'h8;
  localparam ST_RSEL  = 4'h9;
  localparam ST_RROW  = 4'ha;
  localparam ST_RHOLD = 4'hb;
  // reset lands here: the phase timer leaves reset already expired, so the
  // power-up pause needs a state of its own to be loaded
  localparam ST_START = 4'hc;

  // all ns figures here fit in one 100 ns cycle
  localparam [23:0] RAS_CYC  = `CYC_MIN(`RAS_WIDTH_NS);
  localparam [23:0] PRE_CYC  = `CYC_MIN(`RAS_PRECHARGE_NS);
  localparam [23:0] RCD_CYC  = `CYC_MIN(`ROW_TO_SELECT_NS);
  localparam [23:0] SEL_CYC  = `CYC_MIN(`SEL_WIDTH_NS);
  localparam [23:0] ACC_CYC  = `CYC_MIN(`READ_ACCESS_NS);
  localparam [23:0] CSR_CYC  = `CYC_MIN(`SEL_SETUP_NS);
  localparam [3:0]  WAKE_LAST = `WAKE_CYCLES - 1;

  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [3:0]  wakeCnt_r;
  reg         isWrite_r;
  reg         isTest_r;
  reg  [9:0]  col_r;
  reg         tLoad;
  reg  [23:0] tCount;
  wire        tDone;
  wire        idleDone;
  wire        refReq;
  reg         refGrant;
  reg         idleLoad;

  function [23:0] cyc;
    input [23:0] n;
    cyc = (n > 24'h000001) ? n - 24'h000001 : 24'h000000;
  endfunction

  wait_timer #(.W(24)) phaseTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (tLoad),
    .count   (tCount),
    .done_r  (tDone)
  );

  // refresh reloads it too, so a re-wake only follows a stalled scheduler
  wait_timer #(.W(24)) idleTimer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (idleLoad),
    .count   (IDLE_CYC[23:0]),
    .done_r  (idleDone)
  );

  refresh_scheduler #(.INTERVAL(REFRESH_CYC)) refSched (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (initDone_r),
    .grant   (refGrant),
    .req_r   (refReq)
  );

  always @* begin
    state_nxt = state_r;
    tLoad     = 1'b0;
    tCount    = 24'h000000;
    refGrant  = 1'b0;
    idleLoad  = 1'b0;
    case (state_r)
      ST_START: begin
        state_nxt = ST_POWER;
        tLoad     = 1'b1;
        tCount    = cyc(POWERUP_CYC[23:0]);
      end
      ST_POWER: if (tDone) begin
        state_nxt = ST_WAKEA;
        tLoad     = 1'b1;
        tCount    = cyc(RAS_CYC);
      end
      ST_WAKEA: if (tDone) begin
        state_nxt = ST_WAKEP;
        tLoad     = 1'b1;
        tCount    = cyc(PRE_CYC);
      end
      ST_WAKEP: if (tDone) begin
        tLoad  = 1'b1;
        tCount = cyc(RAS_CYC);
        if (wakeCnt_r == WAKE_LAST) begin
          state_nxt = ST_IDLE;
          idleLoad  = 1'b1;
        end else
          state_nxt = ST_WAKEA;
      end
      // refresh and test cycles go ahead of a waiting read or write
      ST_IDLE: begin
        if (idleDone) begin
          state_nxt = ST_WAKEA;
          tLoad     = 1'b1;
          tCount    = cyc(RAS_CYC);
        end else if (refReq || (reqValid && reqTest)) begin
          state_nxt = ST_RSEL;
          refGrant  = refReq;
          idleLoad  = 1'b1;
          tLoad     = 1'b1;
          tCount    = cyc(CSR_CYC);
        end else if (reqValid) begin
          state_nxt = ST_ROW;
          idleLoad  = 1'b1;
          tLoad     = 1'b1;
          tCount    = cyc(RCD_CYC);
        end
      end
      ST_ROW: if (tDone) begin
        state_nxt = ST_SEL;
        tLoad     = 1'b1;
        tCount    = cyc(isWrite_r ? SEL_CYC : ACC_CYC);
      end
      // one column per row opening; bursts on an open row are not issued
      ST_SEL: if (tDone) begin
        state_nxt = ST_HOLD;
        tLoad     = 1'b1;
        tCount    = cyc(RAS_CYC);
      end
      ST_HOLD: if (tDone) begin
        state_nxt = ST_CLOSE;
      end
      ST_CLOSE: begin
        state_nxt = ST_PRE;
        tLoad     = 1'b1;
        tCount    = cyc(PRE_CYC);
      end
      ST_PRE: if (tDone) state_nxt = ST_IDLE;
      ST_RSEL: if (tDone) begin
        state_nxt = ST_RROW;
        tLoad     = 1'b1;
        tCount    = cyc(RAS_CYC);
      end
      ST_RROW: if (tDone) state_nxt = ST_RHOLD;
      ST_RHOLD: begin
        state_nxt = ST_PRE;
        tLoad     = 1'b1;
        tCount    = cyc(PRE_CYC);
      end
      default: state_nxt = ST_START;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r      <= ST_START;
      wakeCnt_r    <= 4'h0;
      isWrite_r    <= 1'b0;
      isTest_r     <= 1'b0;
      col_r        <= 10'h000;
      reqReady_r   <= 1'b0;
      rspValid_r   <= 1'b0;
      rspData_r    <= 4'h0;
      initDone_r   <= 1'b0;
      muxAddr_r    <= 10'h000;
      rowStrobeN_r <= 1'b1;
      selStrobeN_r <= 1'b1;
      writeN_r     <= 1'b1;
      outEnN_r     <= 1'b1;
      dataOut_r    <= 4'h0;
      dataOeN_r    <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      reqReady_r <= 1'b0;
      rspValid_r <= 1'b0;
      case (state_r)
        ST_POWER: begin
          wakeCnt_r <= 4'h0;
          // first wake cycle opens here, the other seven from the precharge state
          if (tDone)
            rowStrobeN_r <= 1'b0;
        end
        ST_WAKEA: if (tDone) rowStrobeN_r <= 1'b1;
        ST_WAKEP: if (tDone) begin
          if (wakeCnt_r == WAKE_LAST) begin
            wakeCnt_r  <= 4'h0;
            initDone_r <= 1'b1;
          end else begin
            wakeCnt_r    <= wakeCnt_r + 4'h1;
            rowStrobeN_r <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (idleDone) begin
            initDone_r   <= 1'b0;
            rowStrobeN_r <= 1'b0;
          end else if (refReq || (reqValid && reqTest)) begin
            isTest_r     <= ~refReq;
            reqReady_r   <= ~refReq;
            selStrobeN_r <= 1'b0;
            writeN_r     <= refReq;
          end else if (reqValid) begin
            isWrite_r    <= reqWrite;
            col_r        <= reqAddr[9:0];
            reqReady_r   <= 1'b1;
            muxAddr_r    <= reqAddr[19:10];
            rowStrobeN_r <= 1'b0;
            writeN_r     <= ~reqWrite;
            dataOut_r    <= reqData;
            dataOeN_r    <= ~reqWrite;
          end
        end
        ST_ROW: if (tDone) begin
          muxAddr_r    <= col_r;
          selStrobeN_r <= 1'b0;
          outEnN_r     <= isWrite_r;
        end
        ST_SEL: if (tDone && !isWrite_r) begin
          rspData_r  <= dataIn;
          rspValid_r <= 1'b1;
        end
        ST_HOLD: if (tDone) begin
          rowStrobeN_r <= 1'b1;
          selStrobeN_r <= 1'b1;
          outEnN_r     <= 1'b1;
        end
        ST_CLOSE: begin
          writeN_r  <= 1'b1;
          dataOeN_r <= 1'b1;
          // parked a cycle after row rise, well past the column hold
          muxAddr_r <= 10'h000;
        end
        ST_RSEL: if (tDone) rowStrobeN_r <= 1'b0;
        // select rises with row; one cycle past the row fall covers its hold
        ST_RROW: if (tDone) begin
          rowStrobeN_r <= 1'b1;
          selStrobeN_r <= 1'b1;
        end
        ST_RHOLD: writeN_r <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule

// >>> testbench/sc_dram_ctrl_assertions.sv
// pin sequencing checks for sc_dram_ctrl
// assumes bind to sc_dram_ctrl, sees its ports only
module sc_dram_ctrl_assertions #(
  parameter POWERUP_CYC = 20
) (
  input wire logic        ref_clk,      // clock
  input wire logic        rst,          // reset
  input wire logic        reqReady_r,   // taken
  input wire logic        reqTest,      // test entry
  input wire logic [19:0] reqAddr,      // address
  input wire logic        initDone_r,   // woken
  input wire logic [9:0]  muxAddr_r,    // address pins
  input wire logic        rowStrobeN_r, // row strobe
  input wire logic        selStrobeN_r, // select
  input wire logic        writeN_r,     // write
  input wire logic        outEnN_r,     // output enable
  input wire logic [3:0]  dataOut_r,    // write data
  input wire logic        dataOeN_r     // data enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] sinceRst_r;
  logic [3:0]  wakes_r;
  logic        rowPrev_r;
  // wake count only runs while not woken, so it holds at the rise
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sinceRst_r <= 16'h0000;
      wakes_r    <= 4'h0;
      rowPrev_r  <= 1'b1;
    end else begin
      rowPrev_r <= rowStrobeN_r;
      if (sinceRst_r != 16'hffff)
        sinceRst_r <= sinceRst_r + 16'h0001;
      if (initDone_r)
        wakes_r <= 4'h0;
      else if (rowPrev_r && !rowStrobeN_r && wakes_r != 4'hf)
        wakes_r <= wakes_r + 4'h1;
    end
  end
  a_powerup_wait: assert property ($fell(rowStrobeN_r) |-> sinceRst_r >= POWERUP_CYC - 1)
    else $error("row strobe active before power-up pause");
  a_wake_count: assert property ($rose(initDone_r) |-> wakes_r >= 4'h8)
    else $error("too few wake cycles");
  a_row_then_col: assert property (reqReady_r && !reqTest |-> $fell(rowStrobeN_r)
    && selStrobeN_r && muxAddr_r == reqAddr[19:10]
    ##1 !selStrobeN_r && muxAddr_r == $past(reqAddr[9:0]))
    else $error("row then column order broken");
  a_strobe_width: assert property (reqReady_r && !reqTest |-> !rowStrobeN_r [*3])
    else $error("row strobe too short");
  a_read_write_high: assert property ($fell(selStrobeN_r) && !rowStrobeN_r && writeN_r
    |-> $past(writeN_r) ##0 writeN_r [*4])
    else $error("write strobe moved in read");
  a_early_write: assert property ($fell(selStrobeN_r) && !rowStrobeN_r && !writeN_r
    |-> !$past(writeN_r) && !dataOeN_r && $stable(dataOut_r))
    else $error("early write data or order wrong");
  a_col_hold: assert property ($rose(rowStrobeN_r) && !$past(outEnN_r) |-> $stable(muxAddr_r))
    else $error("column moved at row rise");
  a_refresh_setup: assert property ($fell(rowStrobeN_r) && !selStrobeN_r |-> !$past(selStrobeN_r))
    else $error("select not ahead of row");
  a_refresh_write: assert property ($fell(rowStrobeN_r) && !selStrobeN_r |-> $stable(writeN_r))
    else $error("write strobe moved at refresh");
  a_test_entry: assert property (reqReady_r && reqTest
    |-> ##[0:4] ($fell(rowStrobeN_r) && !selStrobeN_r && !writeN_r))
    else $error("test entry cycle missing");
endmodule

bind sc_dram_ctrl sc_dram_ctrl_assertions #(.POWERUP_CYC(POWERUP_CYC)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .reqReady_r(reqReady_r), .reqTest(reqTest),
  .reqAddr(reqAddr), .initDone_r(initDone_r), .muxAddr_r(muxAddr_r),
  .rowStrobeN_r(rowStrobeN_r), .selStrobeN_r(selStrobeN_r), .writeN_r(writeN_r),
  .outEnN_r(outEnN_r), .dataOut_r(dataOut_r), .dataOeN_r(dataOeN_r));

// >>> testbench/dram_model.sv
// behavioural 1M x 4 static-column dram at its pins
// assumes strobes change together on a clock edge; samples 1 ns later
module dram_model (
  input  wire logic [9:0] addr,      // address pins
  input  wire logic       rowN,      // row strobe
  input  wire logic       selN,      // select
  input  wire logic       wrN,       // write
  input  wire logic       oeN,       // output enable
  input  wire logic [3:0] dIn,       // controller data
  output logic      [3:0] dq,        // our data
  output logic            drive,     // we drive
  output logic            testMode,  // test mode on
  output int              refreshes, // refreshes seen
  output int              wakes      // row cycles seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [bit [19:0]];
  logic [9:0] row;
  logic       open = 1'b0;
  logic [3:0] lastQ = 4'h0;
  initial testMode = 1'b0;
  initial refreshes = 0;
  initial wakes = 0;
  always @(negedge rowN) begin
    #1;
    wakes++;
    if (!selN) begin
      refreshes++;
      testMode = !wrN;
    end else begin
      row = addr;
      open = 1'b1;
    end
  end
  always @(posedge rowN) open = 1'b0;
  always @(negedge selN) begin
    #1;
    if (open && !wrN)
      mem[{row, addr}] = dIn;
  end
  // read-write: data taken when the write strobe falls after select
  always @(negedge wrN) begin
    #1;
    if (open && !selN)
      mem[{row, addr}] = dIn;
  end
  // column follows the pins; released pins show no stale value
  always @* begin
    drive = open && !selN && !oeN && wrN;
    if (drive) begin
      dq = mem.exists({row, addr}) ? mem[{row, addr}] : 4'h5;
      lastQ = dq;
    end else
      dq = ~lastQ;
  end
endmodule

// >>> testbench/tb.sv
// self-checking bench for sc_dram_ctrl with a behavioural dram
// assumes the design header is on the include path
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PUC = 20;
  localparam int RFC = 40;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic        reqTest = 1'b0;
  logic [19:0] reqAddr = 20'h00000;
  logic [3:0]  reqData = 4'h0;
  wire         reqReady_r, rspValid_r, initDone_r, rowStrobeN_r, selStrobeN_r;
  wire         writeN_r, outEnN_r, dataOeN_r, drive, testMode;
  wire  [3:0]  rspData_r, dataOut_r, dq, dataIn;
  wire  [9:0]  muxAddr_r;
  wire  [4:0]  pins = {rowStrobeN_r, selStrobeN_r, writeN_r, outEnN_r, dataOeN_r};
  int          refreshes, wakes, clash = 0, n_fail = 0, n_checks = 0;
  assign dataIn = dataOeN_r ? dq : dataOut_r;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (drive && dataOeN_r === 1'b0) clash++;
  sc_dram_ctrl #(.POWERUP_CYC(PUC), .IDLE_CYC(5000), .REFRESH_CYC(RFC)) u_sc_dram_ctrl (
    .ref_clk(ref_clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqTest(reqTest), .reqAddr(reqAddr), .reqData(reqData), .reqReady_r(reqReady_r),
    .rspValid_r(rspValid_r), .rspData_r(rspData_r), .initDone_r(initDone_r),
    .muxAddr_r(muxAddr_r), .rowStrobeN_r(rowStrobeN_r), .selStrobeN_r(selStrobeN_r),
    .writeN_r(writeN_r), .outEnN_r(outEnN_r), .dataIn(dataIn), .dataOut_r(dataOut_r),
    .dataOeN_r(dataOeN_r));
  dram_model u_dram_model (.addr(muxAddr_r), .rowN(rowStrobeN_r), .selN(selStrobeN_r),
    .wrN(writeN_r), .oeN(outEnN_r), .dIn(dataOut_r), .dq(dq), .drive(drive),
    .testMode(testMode), .refreshes(refreshes), .wakes(wakes));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // held until ready is seen at an edge, released by that same edge
  task automatic req(input logic w, input logic t, input logic [19:0] a, input logic [3:0] d);
    int k;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqTest <= t;
    reqAddr <= a;
    reqData <= d;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (reqReady_r !== 1'b1 && k < 2000);
    chk("ready", 32'h1, 32'(reqReady_r));
    chk("ready only when woken", 32'h1, 32'(initDone_r));
    reqValid <= 1'b0;
    reqTest <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [3:0] exp);
    int k;
    req(1'b0, 1'b0, a, 4'h0);
    k = 0;
    while (rspValid_r !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    chk("read data", 32'(exp), 32'(rspData_r));
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("pins in reset", 32'h1f, 32'(pins));
    chk("woken in reset", 32'h0, 32'(initDone_r));
    rst <= 1'b0;
  endtask
  task automatic t_init;
    int k;
    int w0;
    w0 = wakes;
    k = 0;
    while (initDone_r !== 1'b1 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
    chk("woken", 32'h1, 32'(initDone_r));
    chk("power-up pause", 32'h1, 32'(k >= PUC));
    chk("wake cycles", 32'h1, 32'(wakes - w0 >= 8));
  endtask
  // corners of row and column, written back to back then read
  task automatic t_rw;
    logic [19:0] adr [5] = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00, 20'h5a5a5};
    for (int i = 0; i < 5; i++)
      req(1'b1, 1'b0, adr[i], 4'(i * 5 + 3));
    for (int i = 0; i < 5; i++)
      rd(adr[i], 4'(i * 5 + 3));
  endtask
  task automatic t_refresh;
    int r0;
    r0 = refreshes;
    repeat (10 * RFC) @(posedge ref_clk);
    chk("refresh rate", 32'h1, 32'((refreshes - r0) inside {[9:11]}));
  endtask
  task automatic t_test;
    int r0;
    int k;
    // start just behind a refresh, so the next one cannot clear test mode early
    r0 = refreshes;
    k = 0;
    while (refreshes == r0 && k < 4 * RFC) begin
      @(posedge ref_clk);
      k++;
    end
    req(1'b0, 1'b1, 20'h00000, 4'h0);
    repeat (6) @(posedge ref_clk);
    chk("test entry", 32'h1, 32'(testMode));
    repeat (RFC + 20) @(posedge ref_clk);
    chk("test exit", 32'h0, 32'(testMode));
    rd(20'hfffff, 4'h8);
  endtask
  initial begin
    t_reset;
    t_init;
    t_rw;
    t_refresh;
    t_test;
    t_reset;
    rd(20'h5a5a5, 4'h7);
    chk("data pin clash", 32'h0, 32'(clash));
    stop_test;
  end
  initial begin
    #2000000;
    n_fail++;
    stop_test;
  end
endmodule
